// ---- core/stl_tune_top.sv ----
// servo tuning stage: torque filter chain, dead band, gain switching
// assumes AXI4-Lite master on core_clk_in; ext_pulse_in is an async pin
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// [RULE1] torque command passes a chain of low-pass and notch sections
// [RULE2] low-pass sections bypass at cutoff zero, else 10..1000 Hz, reset zero
// [RULE3] notch sections bypass at centre zero, else 40..1000 Hz, reset zero
// [RULE4] each notch has Q 0.10..5.00, reset 0.25; lower Q widens notch
// [RULE5] position deviation forced to zero when magnitude under dead band
// [RULE6] dead band 0..4095 half pulses, reset zero, write needs password
// [RULE7] threshold zero disables switching; moving gains always applied
// [RULE8] nonzero threshold: stopping gains when stopped and error under threshold
// [RULE9] nonzero dwell timer: error must stay under threshold longer than it
// [RULE10] moving gains forced during internal or external pulse commands
// [RULE11] external pulses slower than 10 kpps count as no pulse input
// [RULE12] readable monitor shows which gain set is applied
// [RULE13] position gains 0.01..10.00 reset 0.05; velocity 0.10..255.00 reset 0.50
// [RULE14] host enables at most two filters, preferably above 100 Hz
module stl_tune_top import stl_pkg::*; (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [15:0] torque_cmd_in,
  input wire logic torque_stb_in,
  output logic signed [15:0] torque_filt_out,
  output logic torque_stb_out,
  input wire logic signed [31:0] pos_dev_in,
  output logic signed [31:0] pos_dev_out,
  input wire logic signed [31:0] pos_err_in,
  input wire logic motor_stopped_in,
  input wire logic int_pulse_gen_in,
  input wire logic ext_pulse_in,
  output logic [POS_GAIN_W-1:0] pos_gain_out,
  output logic [VEL_GAIN_W-1:0] vel_gain_out,
  output logic gain_set_monitor_out
);
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [FREQ_W-1:0] lp1, lp2, n1c, n2c;
    logic [QUAL_W-1:0] n1q, n2q;
    logic [DB_W-1:0] db;
    logic unlock;
    logic [GTH_W-1:0] gth;
    logic [GTM_W-1:0] gtm;
    logic [POS_GAIN_W-1:0] pgm, pgs;
    logic [VEL_GAIN_W-1:0] vgm, vgs;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [15:0] gap;
    logic pulse_act;
    logic [15:0] pres;
    logic [GTM_W-1:0] dwell;
    logic stop;
    logic signed [31:0] dev;
    logic [POS_GAIN_W-1:0] pos_app;
    logic [VEL_GAIN_W-1:0] vel_app;
  } stl_state_t;

  localparam stl_state_t RST = '{
    n1q: QUAL_W'(Q_RST), n2q: QUAL_W'(Q_RST), // [RULE4]
    pgm: POS_GAIN_W'(POS_GAIN_RST), pgs: POS_GAIN_W'(POS_GAIN_RST), // [RULE13]
    pos_app: POS_GAIN_W'(POS_GAIN_RST),
    vgm: VEL_GAIN_W'(VEL_GAIN_RST), vgs: VEL_GAIN_W'(VEL_GAIN_RST),
    vel_app: VEL_GAIN_W'(VEL_GAIN_RST),
    default: '0
  };

  stl_state_t s_reg, s_next;

  // ==========================================
  // register read map
  function automatic logic [32:0] rd_word(input stl_state_t s, input logic [7:0] a);
    case (a)
      OFS_LP1: rd_word = {1'b1, 32'(s.lp1)};
      OFS_LP2: rd_word = {1'b1, 32'(s.lp2)};
      OFS_N1C: rd_word = {1'b1, 32'(s.n1c)};
      OFS_N1Q: rd_word = {1'b1, 32'(s.n1q)};
      OFS_N2C: rd_word = {1'b1, 32'(s.n2c)};
      OFS_N2Q: rd_word = {1'b1, 32'(s.n2q)};
      OFS_DB: rd_word = {1'b1, 32'(s.db)};
      OFS_KEY: rd_word = {1'b1, 32'h0000_0000};
      OFS_GTH: rd_word = {1'b1, 32'(s.gth)};
      OFS_GTM: rd_word = {1'b1, 32'(s.gtm)};
      OFS_PGM: rd_word = {1'b1, 32'(s.pgm)};
      OFS_VGM: rd_word = {1'b1, 32'(s.vgm)};
      OFS_PGS: rd_word = {1'b1, 32'(s.pgs)};
      OFS_VGS: rd_word = {1'b1, 32'(s.vgs)};
      // monitor: bit0 stopping set applied
      OFS_STAT: rd_word = {1'b1, 29'h0, s.pulse_act, s.unlock, s.stop}; // [RULE12]
      default: rd_word = {1'b0, 32'h0000_0000};
    endcase
  endfunction

  // range check; out-of-range writes are refused whole
  function automatic logic in_range(input logic [7:0] a, input logic [31:0] v);
    case (a)
      OFS_LP1, OFS_LP2: in_range = v == 0 || (v >= LP_MIN && v <= FREQ_MAX); // [RULE2]
      OFS_N1C, OFS_N2C: in_range = v == 0 || (v >= NT_MIN && v <= FREQ_MAX); // [RULE3]
      OFS_N1Q, OFS_N2Q: in_range = v >= Q_MIN && v <= Q_MAX; // [RULE4]
      OFS_DB: in_range = v < (1 << DB_W); // [RULE6]
      OFS_GTH: in_range = v <= GTH_MAX; // [RULE8]
      OFS_GTM: in_range = v <= GTM_MAX; // [RULE9]
      OFS_PGM, OFS_PGS: in_range = v >= POS_GAIN_MIN && v <= POS_GAIN_MAX; // [RULE13]
      OFS_VGM, OFS_VGS: in_range = v >= VEL_GAIN_MIN && v <= VEL_GAIN_MAX; // [RULE13]
      OFS_KEY: in_range = 1'b1;
      default: in_range = 1'b0;
    endcase
  endfunction

  logic [32:0] wr_old;
  logic [31:0] wr_mask, wr_val;
  logic [32:0] rd_hit;
  logic wr_ok, pulse_edge, below, force_op, tick;
  logic [32:0] err_mag, dev_mag;

  // ==========================================
  // next-state logic
  always_comb begin
    s_next = s_reg;
    wr_old = '0;
    wr_mask = '0;
    wr_val = '0;
    rd_hit = '0;
    wr_ok = 1'b0;
    // pin synchroniser, edge seen after the second flop
    s_next.ext_sync = {s_reg.ext_sync[0], ext_pulse_in};
    s_next.ext_prev = s_reg.ext_sync[1];
    pulse_edge = s_reg.ext_sync[1] & ~s_reg.ext_prev;

    // write channels taken independently
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_have = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
      wr_old = rd_word(s_reg, s_reg.aw_addr);
      for (int i = 0; i < 4; i++) begin
        wr_mask[i*8 +: 8] = {8{s_reg.w_strb[i]}};
      end
      wr_val = (wr_old[31:0] & ~wr_mask) | (s_reg.w_data & wr_mask);
      // dead band writes need a fresh unlock
      wr_ok = wr_old[32] && in_range(s_reg.aw_addr, wr_val)
              && !(s_reg.aw_addr == OFS_DB && !s_reg.unlock); // [RULE6]
      s_next.bvalid = 1'b1;
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wr_ok) begin
        case (s_reg.aw_addr)
          OFS_LP1: s_next.lp1 = FREQ_W'(wr_val);
          OFS_LP2: s_next.lp2 = FREQ_W'(wr_val);
          OFS_N1C: s_next.n1c = FREQ_W'(wr_val);
          OFS_N1Q: s_next.n1q = QUAL_W'(wr_val);
          OFS_N2C: s_next.n2c = FREQ_W'(wr_val);
          OFS_N2Q: s_next.n2q = QUAL_W'(wr_val);
          OFS_DB: s_next.db = DB_W'(wr_val); // [RULE6]
          OFS_GTH: s_next.gth = GTH_W'(wr_val);
          OFS_GTM: s_next.gtm = GTM_W'(wr_val);
          OFS_PGM: s_next.pgm = POS_GAIN_W'(wr_val);
          OFS_VGM: s_next.vgm = VEL_GAIN_W'(wr_val);
          OFS_PGS: s_next.pgs = POS_GAIN_W'(wr_val);
          OFS_VGS: s_next.vgs = VEL_GAIN_W'(wr_val);
          default: s_next.unlock = s_reg.unlock;
        endcase
      end
      // any dead band attempt spends the unlock
      if (s_reg.aw_addr == OFS_DB) begin
        s_next.unlock = 1'b0;
      end else if (s_reg.aw_addr == OFS_KEY) begin
        s_next.unlock = (wr_val == KEY_VALUE);
      end
    end
    // one write at a time: hold off until the response is taken
    s_next.awready = !s_next.aw_have && !s_next.bvalid;
    s_next.wready = !s_next.w_have && !s_next.bvalid;

    // read channel, answer one edge after the address
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      rd_hit = rd_word(s_reg, s_axi_araddr);
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_hit[31:0];
      s_next.rresp = rd_hit[32] ? RESP_OKAY : RESP_SLVERR;
    end
    s_next.arready = !s_next.rvalid;

    // dead band, compared in half pulses
    dev_mag = pos_dev_in[31] ? 33'(-34'(pos_dev_in)) : 33'(pos_dev_in);
    if ({dev_mag, 1'b0} < 34'(s_reg.db)) begin
      s_next.dev = '0; // [RULE5]
    end else begin
      s_next.dev = pos_dev_in;
    end

    // pulse-train activity: a gap longer than one 10 kpps period is idle
    if (pulse_edge) begin
      s_next.gap = '0;
      s_next.pulse_act = 1'b1;
    end else if (s_reg.gap >= 16'(GAP_CYC - 1)) begin
      s_next.pulse_act = 1'b0; // [RULE11]
    end else begin
      s_next.gap = s_reg.gap + 16'h0001;
    end

    // 0.1 ms prescaler for the dwell timer
    tick = (s_reg.pres == 16'(TICK_CYC - 1));
    s_next.pres = tick ? 16'h0000 : s_reg.pres + 16'h0001;

    // gain selection
    err_mag = pos_err_in[31] ? 33'(-34'(pos_err_in)) : 33'(pos_err_in);
    below = err_mag < 33'(s_reg.gth);
    force_op = int_pulse_gen_in || s_reg.pulse_act; // [RULE10]
    if (s_reg.gth == '0 || force_op || !motor_stopped_in || !below) begin
      s_next.dwell = '0; // [RULE7] [RULE8]
      s_next.stop = 1'b0;
    end else if (s_reg.gtm == '0) begin
      s_next.stop = 1'b1; // [RULE8]
    end else begin
      // dwell saturates, so a long stop never wraps back
      if (tick && s_reg.dwell != '1) begin
        s_next.dwell = s_reg.dwell + GTM_W'(1);
      end
      s_next.stop = s_reg.dwell > s_reg.gtm; // [RULE9]
    end
    s_next.pos_app = s_next.stop ? s_reg.pgs : s_reg.pgm;
    s_next.vel_app = s_next.stop ? s_reg.vgs : s_reg.vgm;
  end

  // ==========================================
  // state register; ce low freezes everything
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s_reg <= RST;
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign pos_dev_out = s_reg.dev;
  assign pos_gain_out = s_reg.pos_app;
  assign vel_gain_out = s_reg.vel_app;
  assign gain_set_monitor_out = s_reg.stop;

  // ==========================================
  // filter chain: two low-pass then two notch
  logic signed [15:0] chain [0:4];
  logic chain_stb [0:4];
  logic [FREQ_W-1:0] freq_a [0:3];
  logic [QUAL_W-1:0] qual_a [0:3];

  assign chain[0] = torque_cmd_in;
  assign chain_stb[0] = torque_stb_in;
  assign freq_a[0] = s_reg.lp1;
  assign freq_a[1] = s_reg.lp2;
  assign freq_a[2] = s_reg.n1c;
  assign freq_a[3] = s_reg.n2c;
  assign qual_a[0] = s_reg.n1q;
  assign qual_a[1] = s_reg.n2q;
  assign qual_a[2] = s_reg.n1q;
  assign qual_a[3] = s_reg.n2q;

  // each section adds one cycle of latency, bypassed or not
  for (genvar i = 0; i < 4; i++) begin : g_sec
    stl_filt_sec #(
      .NOTCH(i >= 2),
      .DW(16)
    ) u_sec (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .stb_in(chain_stb[i]),
      .x_in(chain[i]),
      .freq_in(freq_a[i]),
      .qual_in(qual_a[i]),
      .y_out(chain[i+1]),
      .stb_out(chain_stb[i+1])
    ); // [RULE1]
  end

  assign torque_filt_out = chain[4];
  assign torque_stb_out = chain_stb[4];

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_gain_off: assert property (ce_in && s_reg.gth == '0 |=> !gain_set_monitor_out) // [RULE7]
    else $error("stopping gains with switching off");
  chk_force_op: assert property (ce_in && int_pulse_gen_in |=> !gain_set_monitor_out) // [RULE10]
    else $error("stopping gains during internal pulses");
  chk_moving_op: assert property (ce_in && !motor_stopped_in |=> pos_gain_out == $past(s_reg.pgm)) // [RULE8]
    else $error("moving gain not applied while moving");
  chk_dwell_min: assert property ($rose(s_reg.stop) && $past(s_reg.gtm) != '0 // [RULE9]
    |-> $past(s_reg.dwell) > $past(s_reg.gtm))
    else $error("stopping gains before dwell expired");
  chk_dead_zero: assert property (ce_in && {dev_mag, 1'b0} < 34'(s_reg.db) |=> pos_dev_out == 0) // [RULE5]
    else $error("deviation inside dead band passed");
  chk_db_locked: assert property (ce_in && !s_reg.unlock |=> $stable(s_reg.db)) // [RULE6]
    else $error("dead band changed without password");
  chk_pulse_idle: assert property (s_reg.gap >= 16'(GAP_CYC - 1) && ce_in && !pulse_edge |=> !s_reg.pulse_act) // [RULE11]
    else $error("slow pulse train still counted");
  chk_monitor_tie: assert property (gain_set_monitor_out |-> pos_gain_out == $past(s_reg.pgs, 1)) // [RULE12]
    else $error("monitor and applied gain disagree");
  chk_q_range: assert property (s_reg.n1q >= QUAL_W'(Q_MIN) && s_reg.n1q <= QUAL_W'(Q_MAX) // [RULE4]
    && s_reg.n2q >= QUAL_W'(Q_MIN) && s_reg.n2q <= QUAL_W'(Q_MAX))
    else $error("notch quality out of range");

  cov_stop_gain: cover property ($rose(gain_set_monitor_out));
  cov_pulse_force: cover property (s_reg.pulse_act && motor_stopped_in && below);
  cov_lock_reject: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cov_filter_on: cover property (torque_stb_out && s_reg.lp1 != '0);
endmodule

// ---- core/stl_pkg.sv ----
// constants shared by the servo tuning stage
// assumes a 25 MHz core clock and a fixed torque sample rate
package stl_pkg;
  // ==========================================
  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SAMPLE_HZ = 10_000;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int MIN_PPS = 10_000;
  localparam int GAP_CYC = CLK_HZ / MIN_PPS;
  // 2*pi/fs in Q16, per hertz of setting
  localparam int COEF_Q16 = int'(6.2831853 * 65536.0 / SAMPLE_HZ);
  localparam int FRAC = 8;
  localparam int Q_ONE = 100 * 65536;
  // ==========================================
  // field widths and ranges
  localparam int FREQ_W = 10;
  localparam int QUAL_W = 9;
  localparam int DB_W = 12;
  localparam int GTH_W = 22;
  localparam int GTM_W = 17;
  localparam int POS_GAIN_W = 10;
  localparam int VEL_GAIN_W = 15;
  localparam int LP_MIN = 10;
  localparam int NT_MIN = 40;
  localparam int FREQ_MAX = 1000;
  localparam int Q_MIN = 10;
  localparam int Q_MAX = 500;
  localparam int Q_RST = 25;
  localparam int GTH_MAX = 2_621_439;
  localparam int GTM_MAX = 100_000;
  localparam int POS_GAIN_MIN = 1;
  localparam int POS_GAIN_MAX = 1000;
  localparam int POS_GAIN_RST = 5;
  localparam int VEL_GAIN_MIN = 10;
  localparam int VEL_GAIN_MAX = 25_500;
  localparam int VEL_GAIN_RST = 50;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFS_LP1 = 8'h00;
  localparam logic [7:0] OFS_LP2 = 8'h04;
  localparam logic [7:0] OFS_N1C = 8'h08;
  localparam logic [7:0] OFS_N1Q = 8'h0C;
  localparam logic [7:0] OFS_N2C = 8'h10;
  localparam logic [7:0] OFS_N2Q = 8'h14;
  localparam logic [7:0] OFS_DB = 8'h18;
  localparam logic [7:0] OFS_KEY = 8'h1C;
  localparam logic [7:0] OFS_GTH = 8'h20;
  localparam logic [7:0] OFS_GTM = 8'h24;
  localparam logic [7:0] OFS_PGM = 8'h28;
  localparam logic [7:0] OFS_VGM = 8'h2C;
  localparam logic [7:0] OFS_PGS = 8'h30;
  localparam logic [7:0] OFS_VGS = 8'h34;
  localparam logic [7:0] OFS_STAT = 8'h38;
  // password value, arbitrary
  localparam logic [31:0] KEY_VALUE = 32'h00C0_FFEE;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- core/stl_filt_sec.sv ----
// one torque filter section: one-pole low-pass or state-variable notch
// assumes stb_in pulses once per torque sample at SAMPLE_HZ
`timescale 1ns/1ps
module stl_filt_sec import stl_pkg::*; #(
  parameter bit NOTCH = 1'b0,
  parameter int DW = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic stb_in,
  input wire logic signed [DW-1:0] x_in,
  input wire logic [FREQ_W-1:0] freq_in,
  input wire logic [QUAL_W-1:0] qual_in,
  output logic signed [DW-1:0] y_out,
  output logic stb_out
);
  typedef struct packed {
    logic signed [31:0] low;
    logic signed [31:0] band;
    logic signed [DW-1:0] y;
    logic stb;
  } stl_fsec_t;
  stl_fsec_t s_reg, s_next;
  logic signed [31:0] xs, f, d, low_n, high;

  function automatic logic signed [31:0] mulq(input logic signed [31:0] a, input logic signed [31:0] b);
    mulq = 32'((64'(a) * 64'(b)) >>> 16);
  endfunction

  // ==========================================
  // section update, once per sample
  always_comb begin
    s_next = s_reg;
    s_next.stb = stb_in;
    xs = 32'(x_in) <<< FRAC;
    f = 32'(32'(freq_in) * COEF_Q16);
    // damping is 1/Q; small Q gives a wide notch
    d = 32'(Q_ONE / ((qual_in == '0) ? 1 : int'(qual_in))); // [RULE4]
    low_n = s_reg.low;
    high = '0;
    if (stb_in) begin
      if (freq_in == '0) begin
        s_next.y = x_in; // [RULE2] [RULE3]
      end else if (!NOTCH) begin
        low_n = s_reg.low + mulq(f, xs - s_reg.low);
        s_next.low = low_n;
        s_next.y = DW'(low_n >>> FRAC);
      end else begin
        // no saturation: wide-band inputs near fs/6 can wrap
        low_n = s_reg.low + mulq(f, s_reg.band);
        high = xs - low_n - mulq(d, s_reg.band);
        s_next.low = low_n;
        s_next.band = s_reg.band + mulq(f, high);
        s_next.y = DW'((high + low_n) >>> FRAC);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign y_out = s_reg.y;
  assign stb_out = s_reg.stb;

  chk_bypass_pass: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [RULE2]
    ce_in && stb_in && freq_in == '0 |=> y_out == $past(x_in))
    else $error("bypassed section altered sample");
endmodule

// ---- dv/stl_pulse_src.sv ----
// external pulse-train source standing in front of ext_pulse_in
// assumes the bench sets the period in core clock cycles, 50 % duty
`timescale 1ns/1ps
module stl_pulse_src (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic [15:0] period_in,
  output logic pulse_out
);
  // ==========================================
  // pulse generator
  int cnt;
  // wrap when the period shrinks mid-run so the count never runs away
  always @(posedge clk_in) begin
    if (!en_in) begin
      cnt <= 0;
      pulse_out <= 1'b0;
    end else begin
      cnt <= (cnt + 1 >= period_in) ? 0 : cnt + 1;
      pulse_out <= (cnt < period_in / 2);
    end
  end
endmodule

// ---- dv/servo_loop_tuning_bench.sv ----
// self-checking bench for the servo tuning stage
// assumes one 25 MHz clock, an AXI4-Lite host task set and a pulse source
`timescale 1ns/1ps
module servo_loop_tuning_bench import stl_pkg::*; ;
  // ==========================================
  // signals
  logic clk = 1'b0;
  logic rst_n, ce, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic signed [15:0] tq_in, tq_out;
  logic tq_stb, tq_stb_o, stopped, int_gen, ext_pulse, pulse_en, mon;
  logic signed [31:0] dev_in, dev_out, err_in, dev_exp;
  logic [15:0] period;
  logic [POS_GAIN_W-1:0] pos_gain;
  logic [VEL_GAIN_W-1:0] vel_gain;
  logic [31:0] rst_tab [14] = '{0, 0, 0, 25, 0, 25, 0, 0, 0, 0, 5, 50, 5, 50};
  int failures, comparisons, dev_n, db_m, i;
  int seed = 83;
  bit dev_on, lp_on;
  logic signed [15:0] tq_q [$];

  always #20 clk = ~clk;

  stl_tune_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .torque_cmd_in(tq_in), .torque_stb_in(tq_stb), .torque_filt_out(tq_out), .torque_stb_out(tq_stb_o),
    .pos_dev_in(dev_in), .pos_dev_out(dev_out), .pos_err_in(err_in), .motor_stopped_in(stopped),
    .int_pulse_gen_in(int_gen), .ext_pulse_in(ext_pulse), .pos_gain_out(pos_gain), .vel_gain_out(vel_gain),
    .gain_set_monitor_out(mon));

  stl_pulse_src pulse_src (.clk_in(clk), .en_in(pulse_en), .period_in(period), .pulse_out(ext_pulse));

  // ==========================================
  // comparison and closing
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 6000) begin
      failures++;
      give_verdict();
    end
  endtask

  // ==========================================
  // host bus tasks
  // the leading edge keeps two calls from driving one signal in one step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 6000; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    hang(n);
    bready <= 1'b0;
    check("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 6000; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    hang(n);
    rready <= 1'b0;
    check("rresp", 32'(rresp), 32'(er));
    check("rdata", rdata, d);
  endtask

  // refused value gets SLVERR, accepted one gets OKAY and reads back
  task automatic try(input logic [7:0] a, input logic [31:0] bad, input logic [31:0] good);
    axi_wr(a, bad, RESP_SLVERR);
    axi_wr(a, good, RESP_OKAY);
    axi_rd(a, good, RESP_OKAY);
  endtask

  // model gain sets: moving 100/200, stopping 7/60
  task automatic gains(input bit stop);
    repeat (3) @(posedge clk);
    check("monitor", 32'(mon), 32'(stop));
    check("pos gain", 32'(pos_gain), stop ? 32'd7 : 32'd100);
    check("vel gain", 32'(vel_gain), stop ? 32'd60 : 32'd200);
  endtask

  task automatic wait_rise();
    int n;
    for (n = 0; n < 6000 && ext_pulse !== 1'b0; n++) @(posedge clk);
    hang(n);
    for (n = 0; n < 6000 && ext_pulse !== 1'b1; n++) @(posedge clk);
    hang(n);
  endtask

  // ==========================================
  // result models: torque queue and dead band
  always @(posedge clk) begin
    if (tq_stb_o === 1'b1 && !lp_on) begin
      if (tq_q.size() == 0) check("torque extra", 32'd1, 32'd0);
      else check("torque", 32'(tq_out), 32'(tq_q.pop_front()));
    end
    if (tq_stb && rst_n && !lp_on) tq_q.push_back(tq_in);
    if (dev_on) begin
      if (dev_n > 0) check("deviation", dev_out, dev_exp);
      dev_n++;
      dev_exp = (2 * (dev_in < 0 ? -dev_in : dev_in) < db_m) ? 32'sd0 : dev_in;
    end
  end

  // ==========================================
  // main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, tq_stb, stopped, int_gen, pulse_en} = '0;
    {awaddr, araddr, wdata, tq_in, dev_in, err_in} = '0;
    ce = 1'b1;
    period = 16'd100;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 14; i++) axi_rd(8'(i * 4), rst_tab[i], RESP_OKAY);
    $display("test reset values done");
    try(OFS_LP1, 32'd9, 32'd1000);
    try(OFS_LP2, 32'd1001, 32'd10);
    try(OFS_N1C, 32'd39, 32'd40);
    try(OFS_N2C, 32'd1001, 32'd1000);
    try(OFS_N1Q, 32'd9, 32'd500);
    try(OFS_N2Q, 32'd501, 32'd10);
    try(OFS_GTH, 32'd2621440, 32'd2621439);
    try(OFS_GTM, 32'd100001, 32'd100000);
    try(OFS_PGM, 32'd0, 32'd1000);
    try(OFS_VGS, 32'd25501, 32'd10);
    axi_wr(OFS_STAT, 32'd1, RESP_SLVERR);
    axi_wr(8'h3C, 32'd1, RESP_SLVERR);
    axi_rd(8'h3C, 32'd0, RESP_SLVERR);
    $display("test ranges done");
    // host should keep at most two filters on but the range tests left all four on; bypass all for the pass-through check
    axi_wr(OFS_LP1, 32'd0, RESP_OKAY);
    axi_wr(OFS_LP2, 32'd0, RESP_OKAY);
    axi_wr(OFS_N1C, 32'd0, RESP_OKAY);
    axi_wr(OFS_N2C, 32'd0, RESP_OKAY);
    repeat (40) begin
      @(posedge clk);
      tq_in <= 16'($random(seed));
      tq_stb <= 1'b1;
      @(posedge clk);
      tq_stb <= 1'b0;
      @(posedge clk);
    end
    repeat (8) @(posedge clk);
    check("torque pending", 32'(tq_q.size()), 32'd0);
    $display("test torque bypass done");
    // one low-pass at 200 Hz: a step is slowed, then settles to the input
    axi_wr(OFS_LP1, 32'd200, RESP_OKAY);
    lp_on = 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      tq_in <= 16'sd1000;
      tq_stb <= 1'b1;
      @(posedge clk);
      tq_stb <= 1'b0;
      repeat (6) @(posedge clk);
      if (i == 0) check("lp step", 32'(tq_out < 16'sd1000), 32'd1);
    end
    check("lp settle", 32'(tq_out >= 16'sd999 && tq_out <= 16'sd1000), 32'd1);
    $display("test low-pass done");
    axi_wr(OFS_DB, 32'd9, RESP_SLVERR);
    axi_wr(OFS_KEY, KEY_VALUE, RESP_OKAY);
    axi_wr(OFS_DB, 32'd4096, RESP_SLVERR);
    axi_wr(OFS_KEY, KEY_VALUE, RESP_OKAY);
    axi_wr(OFS_DB, 32'd9, RESP_OKAY);
    axi_rd(OFS_STAT, 32'd0, RESP_OKAY);
    db_m = 9;
    dev_on = 1'b1;
    repeat (300) begin
      @(posedge clk);
      dev_in <= $random(seed) % 8;
    end
    dev_on = 1'b0;
    $display("test dead band done");
    axi_wr(OFS_GTH, 32'd0, RESP_OKAY);
    axi_wr(OFS_GTM, 32'd0, RESP_OKAY);
    axi_wr(OFS_PGM, 32'd100, RESP_OKAY);
    axi_wr(OFS_VGM, 32'd200, RESP_OKAY);
    axi_wr(OFS_PGS, 32'd7, RESP_OKAY);
    axi_wr(OFS_VGS, 32'd60, RESP_OKAY);
    stopped <= 1'b1;
    gains(1'b0);
    axi_wr(OFS_GTH, 32'd50, RESP_OKAY);
    gains(1'b1);
    axi_rd(OFS_STAT, 32'd1, RESP_OKAY);
    err_in <= -32'sd50;
    gains(1'b0);
    err_in <= -32'sd49;
    gains(1'b1);
    stopped <= 1'b0;
    gains(1'b0);
    stopped <= 1'b1;
    int_gen <= 1'b1;
    gains(1'b0);
    int_gen <= 1'b0;
    pulse_en <= 1'b1;
    repeat (300) @(posedge clk);
    gains(1'b0);
    period <= 16'd5000;
    wait_rise();
    repeat (2700) @(posedge clk);
    gains(1'b1);
    pulse_en <= 1'b0;
    $display("test gain switch done");
    stopped <= 1'b0;
    axi_wr(OFS_GTM, 32'd3, RESP_OKAY);
    stopped <= 1'b1;
    repeat (7000) @(posedge clk);
    check("dwell early", 32'(mon), 32'd0);
    repeat (3100) @(posedge clk);
    check("dwell late", 32'(mon), 32'd1);
    $display("test dwell timer done");
    give_verdict();
  end
endmodule
